// ### rtl/pdm_pkg.sv
// Constants and carrier types for the pulse period and duty meter.
// Assumes one 25 MHz system clock; results are kept in 10 ns units.
`default_nettype none
package pdm_pkg;

    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          UNIT_NS         = 10;
    // Each clock advances the period counter cnt by this many 10 ns units
    localparam logic [31:0] TICKS_PER_CLK   = 32'(CLK_PERIOD_NS / UNIT_NS);
    // Longest supported period, from the 5.96 Hz floor, rounded down
    localparam int          LONGEST_PERIOD_NS = 167785234;
    localparam int          TIMEOUT_CYCLES  = LONGEST_PERIOD_NS / CLK_PERIOD_NS;
    // Frequency in Hz is this numerator over the period in units
    localparam logic [31:0] FREQ_NUM        = 32'(1000000000 / UNIT_NS);
    localparam int          RATIO_FRAC_BITS = 16;
    localparam logic [16:0] RATIO_ONE       = 17'h10000;
    localparam int          DIV_STEPS       = 48;
    localparam logic [5:0]  DIV_LAST        = 6'h2F;
    localparam logic [31:0] RESET_VALUE     = 32'h00000000;

    typedef enum logic {
        rising_edge_polarity,
        falling_edge_polarity
    } pdm_pol_t;

    typedef struct packed {
        logic [31:0] period;
        logic [31:0] duration;
        logic [16:0] ratio;
        logic [31:0] freq;
    } pdm_result_t;

endpackage

`default_nettype wire

// ### rtl/pdm_meter.sv
// Pulse period, active duration, duty ratio and frequency meter.
// Assumes pwm_i is already synchronous to clock_i.
//
// Functional notes
// - Period and active duration are measured continuously in hardware without software help.
// - With rising polarity each period starts on a rising edge and the high time is measured from it.
// - With falling polarity each period starts on a falling edge and the low time is the active pulse.
// - Period and duration are reported as unsigned counts of 10 ns.
// - The duty ratio is duration over period, a fraction from zero to one inclusive.
// - With no edges on the input the reported results stay unchanged.
// - A two-valued status tells whether new measurement data is available or absent.
// - The input frequency is derived from the measured period for any periodic input whose period is within the static timeout.
`timescale 1ns/1ps
`default_nettype none

module pdm_meter #(
    parameter int TIMEOUT_CYC = pdm_pkg::TIMEOUT_CYCLES
) (
    input  wire logic                  clock_i,
    input  wire logic                  reset_i,
    input  wire logic                  pwm_i,
    input  wire pdm_pkg::pdm_pol_t     polarity_i,
    output var  pdm_pkg::pdm_result_t  result_o,
    output logic                       new_measurement_ready_o
);
    import pdm_pkg::*;

    typedef enum logic [1:0] {PDM_IDLE, PDM_RATIO, PDM_FREQ} pdm_state_t;

    pdm_state_t  state;
    logic        pwm_q;
    logic        armed;
    logic        dur_seen;
    logic [31:0] cnt;
    logic [31:0] dur_cap;
    logic [31:0] idle_cnt;
    logic [31:0] snap_period;
    logic [31:0] snap_dur;
    logic [32:0] rem;
    logic [47:0] quo;
    logic [5:0]  step;
    logic [16:0] ratio_res;

    wire         rise_edge   = pwm_i & ~pwm_q;
    wire         fall_edge   = ~pwm_i & pwm_q;
    wire         pol_fall    = (polarity_i == falling_edge_polarity);
    wire         start_edge  = pol_fall ? fall_edge : rise_edge;
    wire         end_edge    = pol_fall ? rise_edge : fall_edge;
    wire         launch      = start_edge & armed & dur_seen & (state == PDM_IDLE);
    wire         timeout     = (idle_cnt == 32'(TIMEOUT_CYC - 1));
    wire [32:0]  div_sh      = {rem[31:0], quo[47]};
    wire         div_ge      = (div_sh >= {1'b0, snap_period});
    wire [32:0]  div_rem     = div_ge ? (div_sh - {1'b0, snap_period}) : div_sh;
    wire [47:0]  div_quo     = {quo[46:0], div_ge};
    wire         div_last    = (step == DIV_LAST);
    wire         publish     = (state == PDM_FREQ) & div_last;

    // Edge capture and time counting in 10 ns units
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            // Load the pin level, so a high input at release is no edge
            pwm_q    <= pwm_i;
            cnt      <= RESET_VALUE;
            dur_cap  <= RESET_VALUE;
            armed    <= 1'b0;
            dur_seen <= 1'b0;
            idle_cnt <= RESET_VALUE;
        end else begin
            pwm_q <= pwm_i;
            if (start_edge) begin
                cnt      <= TICKS_PER_CLK;
                armed    <= 1'b1;
                dur_seen <= 1'b0;
                idle_cnt <= RESET_VALUE;
            end else begin
                cnt      <= cnt + TICKS_PER_CLK;
                idle_cnt <= timeout ? RESET_VALUE : idle_cnt + 32'h00000001;
                if (timeout) begin
                    armed <= 1'b0;
                end
                if (end_edge & armed) begin
                    dur_cap  <= cnt;
                    dur_seen <= 1'b1;
                end
            end
        end
    end

    // Shared restoring divider: duty ratio first, then frequency
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state       <= PDM_IDLE;
            snap_period <= RESET_VALUE;
            snap_dur    <= RESET_VALUE;
            rem         <= 33'h000000000;
            quo         <= 48'h000000000000;
            step        <= 6'h00;
            ratio_res   <= 17'h00000;
        end else begin
            case (state)
                PDM_IDLE: begin
                    if (launch) begin
                        // Snapshot lets the counters run on during the divide
                        snap_period <= cnt;
                        snap_dur    <= dur_cap;
                        rem         <= 33'h000000000;
                        quo         <= {dur_cap, 16'h0000};
                        step        <= 6'h00;
                        state       <= PDM_RATIO;
                    end
                end
                PDM_RATIO: begin
                    rem  <= div_rem;
                    quo  <= div_quo;
                    step <= step + 6'h01;
                    if (div_last) begin
                        ratio_res <= div_quo[16:0];
                        rem       <= 33'h000000000;
                        quo       <= {16'h0000, FREQ_NUM};
                        step      <= 6'h00;
                        state     <= PDM_FREQ;
                    end
                end
                PDM_FREQ: begin
                    rem  <= div_rem;
                    quo  <= div_quo;
                    step <= step + 6'h01;
                    if (div_last) begin
                        state <= PDM_IDLE;
                    end
                end
                default: begin
                    state <= PDM_IDLE;
                end
            endcase
        end
    end

    // Results only move on publish, so a static input leaves them alone
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            result_o                <= '0;
            new_measurement_ready_o <= 1'b0;
        end else begin
            if (publish) begin
                result_o.period   <= snap_period;
                result_o.duration <= snap_dur;
                result_o.ratio    <= ratio_res;
                result_o.freq     <= div_quo[31:0];
            end
            // Set wins over the static-input clear
            if (publish) begin
                new_measurement_ready_o <= 1'b1;
            end else if (timeout && !start_edge) begin
                new_measurement_ready_o <= 1'b0;
            end
        end
    end

    sequence s_launch;
        launch;
    endsequence

    sequence s_published;
        ##97 new_measurement_ready_o;
    endsequence

    property p_launch_divides;
        @(posedge clock_i) disable iff (reset_i)
        s_launch |=> (state == PDM_RATIO) && (snap_period == $past(cnt));
    endproperty
    a_launch_divides: assert property (p_launch_divides) else $error("capture did not start divide");

    property p_rise_restart;
        @(posedge clock_i) disable iff (reset_i)
        (polarity_i == rising_edge_polarity) && pwm_i && !pwm_q |=> cnt == TICKS_PER_CLK;
    endproperty
    a_rise_restart: assert property (p_rise_restart) else $error("rising edge did not start period");

    property p_fall_restart;
        @(posedge clock_i) disable iff (reset_i)
        (polarity_i == falling_edge_polarity) && !pwm_i && pwm_q |=> cnt == TICKS_PER_CLK;
    endproperty
    a_fall_restart: assert property (p_fall_restart) else $error("falling edge did not start period");

    property p_units;
        @(posedge clock_i) disable iff (reset_i)
        !start_edge ##1 !start_edge |-> cnt == $past(cnt) + TICKS_PER_CLK;
    endproperty
    a_units: assert property (p_units) else $error("counter not in 10 ns units");

    property p_ratio_range;
        @(posedge clock_i) disable iff (reset_i)
        publish |=> result_o.ratio <= RATIO_ONE;
    endproperty
    a_ratio_range: assert property (p_ratio_range) else $error("duty ratio above one");

    property p_hold_static;
        @(posedge clock_i) disable iff (reset_i)
        (state == PDM_IDLE) |=> $stable(result_o);
    endproperty
    a_hold_static: assert property (p_hold_static) else $error("results moved without a measurement");

    property p_ready_on_publish;
        @(posedge clock_i) disable iff (reset_i)
        publish |=> new_measurement_ready_o && result_o.period == $past(snap_period);
    endproperty
    a_ready_on_publish: assert property (p_ready_on_publish) else $error("status not set on new data");

    property p_freq_latency;
        @(posedge clock_i) disable iff (reset_i)
        s_launch |-> s_published;
    endproperty
    a_freq_latency: assert property (p_freq_latency) else $error("frequency result late");

    property p_reset_clears;
        @(posedge clock_i)
        reset_i |=> !new_measurement_ready_o && cnt == RESET_VALUE && result_o.period == RESET_VALUE;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left state behind");

    property p_static_clear;
        @(posedge clock_i) disable iff (reset_i)
        timeout && !publish && !start_edge |=> !new_measurement_ready_o && !armed;
    endproperty
    a_static_clear: assert property (p_static_clear) else $error("static input not detected");

endmodule

`default_nettype wire

// ### tb/pdm_pwm_source.sv
// Behavioural pulse source standing in for the external signal.
// Assumes settings change on a rising edge of clock_i.
`timescale 1ns/1ps
`default_nettype none
module pdm_pwm_source (
    input  wire logic        clock_i,
    input  wire logic        run_i,
    input  wire logic        invert_i,
    input  wire logic [15:0] high_i,
    input  wire logic [15:0] period_i,
    output var  logic        pwm_o
);
    logic [15:0] cnt;
    initial begin
        cnt = 16'h0000;
        pwm_o = 1'b0;
    end
    // Stopped source holds its last level, so the input looks static
    always @(posedge clock_i) begin
        if (run_i) begin
            pwm_o <= (cnt < high_i) ^ invert_i;
            cnt <= (cnt + 16'h0001 >= period_i) ? 16'h0000 : cnt + 16'h0001;
        end else begin
            cnt <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ### tb/pwm_period_duty_meter_tb.sv
// Self-checking bench for the pulse period and duty meter.
// Assumes the meter is built with a short static timeout.
`timescale 1ns/1ps
`default_nettype none
module pwm_period_duty_meter_tb;
    import pdm_pkg::*;
    localparam int TMO = 200;
    logic        clock_i;
    logic        reset_i;
    logic        run;
    logic        inv;
    logic [15:0] high;
    logic [15:0] per;
    logic        pwm;
    logic        ready;
    pdm_pol_t    pol;
    pdm_result_t res;
    pdm_result_t last;
    int          n_fail;
    int          check_count;

    pdm_pwm_source src (.clock_i(clock_i), .run_i(run), .invert_i(inv), .high_i(high), .period_i(per), .pwm_o(pwm));
    pdm_meter #(.TIMEOUT_CYC(TMO)) DUT (.clock_i(clock_i), .reset_i(reset_i), .pwm_i(pwm), .polarity_i(pol),
        .result_o(res), .new_measurement_ready_o(ready));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hold the input still past the timeout; results must survive it
    task automatic go_static();
        @(posedge clock_i);
        run <= 1'b0;
        repeat (TMO + 50) @(posedge clock_i);
        #1;
        check("ready static", 32'h0, 32'(ready));
        check("period kept", last.period, res.period);
        check("duration kept", last.duration, res.duration);
        check("ratio kept", 32'(last.ratio), 32'(res.ratio));
        check("freq kept", last.freq, res.freq);
    endtask

    task automatic measure(input pdm_pol_t p, input int h, input int n);
        pdm_result_t e;
        go_static();
        @(posedge clock_i);
        pol <= p;
        inv <= (p == falling_edge_polarity);
        high <= 16'(h);
        per <= 16'(n);
        run <= 1'b1;
        e.period = 32'(4 * n);
        e.duration = 32'(4 * h);
        e.ratio = 17'((h * 65536) / n);
        e.freq = 32'(100000000 / (4 * n));
        repeat (4 * n + 120) @(posedge clock_i);
        #1;
        check("ready", 32'h1, 32'(ready));
        check("period", e.period, res.period);
        check("duration", e.duration, res.duration);
        check("ratio", 32'(e.ratio), 32'(res.ratio));
        check("freq", e.freq, res.freq);
        last = e;
    endtask

    // Reset in mid-run with the input high; release must not count as a start
    // Needs h of at least 10 so the input is still high at release
    task automatic reset_run(input int h, input int n);
        pdm_result_t e;
        go_static();
        e.period = 32'(4 * n);
        e.duration = 32'(4 * h);
        e.ratio = 17'((h * 65536) / n);
        e.freq = 32'(100000000 / (4 * n));
        @(posedge clock_i);
        pol <= rising_edge_polarity;
        inv <= 1'b0;
        high <= 16'(h);
        per <= 16'(n);
        run <= 1'b1;
        reset_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        #1;
        check("rerun reset period", 32'h0, res.period);
        check("rerun reset ready", 32'h0, 32'(ready));
        // A false start at release would publish before this point
        repeat (2 * n + 75) @(posedge clock_i);
        #1;
        check("rerun partial period", 32'h0, 32'(ready));
        repeat (n + 40) @(posedge clock_i);
        #1;
        check("rerun ready", 32'h1, 32'(ready));
        check("rerun period", e.period, res.period);
        check("rerun duration", e.duration, res.duration);
        check("rerun ratio", 32'(e.ratio), 32'(res.ratio));
        check("rerun freq", e.freq, res.freq);
        last = e;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        n_fail++;
        $display("wrong value watchdog expected finish seen hang");
        test_done();
    end

    initial begin
        reset_i = 1'b1;
        run = 1'b0;
        inv = 1'b0;
        high = 16'h0000;
        per = 16'h0001;
        pol = rising_edge_polarity;
        last = '0;
        n_fail = 0;
        check_count = 0;
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        #1;
        check("reset period", 32'h0, res.period);
        check("reset freq", 32'h0, res.freq);
        check("reset ready", 32'h0, 32'(ready));
        measure(rising_edge_polarity, 10, 40);
        measure(rising_edge_polarity, 30, 32);
        measure(falling_edge_polarity, 12, 16);
        measure(falling_edge_polarity, 1, 8);
        reset_run(30, 32);
        go_static();
        test_done();
    end
endmodule
`default_nettype wire
